// ===== logic/dpll_pd_pkg.sv
// Shared constants, register map and carrier types for the loop phase-detector configuration block
package dpll_pd_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the microprocessor port
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN_DAMP = 8'h6B;
  localparam logic [7:0] OFS_AUX_GAIN = 8'h6C;
  localparam logic [7:0] OFS_MAIN_GAIN = 8'h6D;
  localparam logic [7:0] OFS_SHIFT_LO = 8'h70;
  localparam logic [7:0] OFS_SHIFT_HI = 8'h71;
  localparam logic [7:0] OFS_BUILDOUT = 8'h72;
  localparam logic [7:0] OFS_FINE = 8'h73;
  localparam logic [7:0] OFS_COARSE = 8'h74;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MAIN_DAMP = 8'h13;
  localparam logic [7:0] RST_GAIN = 8'hC2;
  localparam logic [7:0] RST_SHIFT_LO = 8'h00;
  localparam logic [7:0] RST_SHIFT_HI = 8'h00;
  localparam logic [7:0] RST_BUILDOUT = 8'h00;
  localparam logic [7:0] RST_FINE = 8'hA2;
  localparam logic [7:0] RST_COARSE = 8'h85;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 7;
  localparam int BIT_WIDE = 6;
  localparam int BIT_MULTI = 5;
  localparam int BIT_INACT = 6;
  localparam int HI_FIELD_MSB = 6;
  localparam int HI_FIELD_LSB = 4;
  localparam int LO_FIELD_MSB = 2;
  localparam int COARSE_MSB = 3;
  localparam logic [5:0] BUILDOUT_MASK = 6'h3F;

  // ----------------------------------------------------------------
  // Damping codes and factors (factor times ten)
  // ----------------------------------------------------------------
  localparam logic [2:0] DAMP_1 = 3'h1;
  localparam logic [2:0] DAMP_2 = 3'h2;
  localparam logic [2:0] DAMP_4 = 3'h4;
  localparam logic [2:0] DAMP_5 = 3'h5;
  localparam logic [7:0] DF_1P2 = 8'h0C;
  localparam logic [7:0] DF_2P5 = 8'h19;
  localparam logic [7:0] DF_5 = 8'h32;
  localparam logic [7:0] DF_10 = 8'h64;
  localparam logic [7:0] DF_20 = 8'hC8;
  // Bandwidth classes: 0 up to 4 Hz, 1 8 Hz, 2 18 Hz, 3 35 Hz, 4 70 Hz
  localparam logic [2:0] BW_8HZ = 3'h1;
  localparam logic [2:0] BW_18HZ = 3'h2;
  localparam logic [2:0] BW_35HZ = 3'h3;
  localparam logic [2:0] BW_70HZ = 3'h4;

  // ----------------------------------------------------------------
  // Phase arithmetic
  // ----------------------------------------------------------------
  localparam int FRAC_W = 11;
  localparam int CYC_W = 15;
  localparam int PH_W = CYC_W + FRAC_W;
  localparam logic [3:0] COARSE_TOP_CODE = 4'hB;
  localparam logic [12:0] SPAN_MAX = 13'h1FFF;
  localparam logic [12:0] SPAN_ONE = 13'h0001;

  // Offset ramp states
  typedef enum logic [1:0] {
    RAMP_HOLD = 2'b01,
    RAMP_MOVE = 2'b10
  } ramp_t;

  // Status of one loop from the surrounding loop logic
  typedef struct packed {
    logic analog_fb;
    logic low_rate;
  } loop_mode_t;

  // Register port request
  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpu_req_t;

  // Whole state of the top module
  typedef struct packed {
    logic [7:0] damp;
    logic [7:0] aux_gain;
    logic [7:0] main_gain;
    logic [7:0] shift_lo;
    logic [7:0] shift_hi;
    logic [7:0] buildout;
    logic [7:0] fine;
    logic [7:0] coarse;
    logic [7:0] rdata;
    logic [7:0] damp_x10;
    logic loss;
    logic [PH_W-1:0] loop_phase;
    logic [15:0] shift_out;
    ramp_t ramp;
  } cfg_state_t;

endpackage

// ===== logic/dpll_phase_detector_config.sv
// Main loop damping, gain for both timing loops, phase shift and phase-loss configuration
`timescale 1ns/10ps

// Behaviour
// - Damping codes 1, 2, 4 and 5 map by bandwidth
// - Damping selection resets to code 011
// - Main loop auto analog low-rate uses damping bits 6:4
// - Digital feedback always uses digital gain
// - Auto off always selects digital gain
// - Fine limit enable gates fine phase loss
// - Coarse limit enable gates coarse phase loss
// - Coarse code sets span 2^(n+1)-1, max 8191
// - Wide-range bit enables multi-cycle tracking
// - Wide-range span from coarse limit field
// - Multi-cycle bit feeds long phase to loop
// - Without multi-cycle, loop phase limited 360 degrees
module dpll_phase_detector_config
  import dpll_pd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  input wire loop_mode_t main_mode,
  input wire loop_mode_t aux_mode,
  input wire logic [2:0] aux_lowrate_analog_gain,
  input wire logic [2:0] main_bw_class,
  input wire logic signed [CYC_W-1:0] meas_cycles,
  input wire logic [FRAC_W-1:0] meas_frac,
  input wire logic [2:0] fine_err,
  input wire logic ref_inactive,
  input wire logic loop_locked,
  input wire logic buildout_on,
  input wire logic ramp_off,
  output logic [2:0] main_loop_damping_sel,
  output logic [7:0] damping_x10,
  output logic [2:0] main_pd_gain,
  output logic [2:0] aux_pd_gain,
  output logic phase_loss,
  output logic wide_range_on,
  output logic multicycle_response_on,
  output logic signed [PH_W-1:0] loop_phase,
  output logic signed [15:0] output_shift,
  output logic [5:0] buildout_mean_shift
);

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  cfg_state_t s_q; // Registered state
  cfg_state_t s_d; // Next state
  logic [12:0] span; // Coarse tracking span in cycles
  logic [CYC_W-1:0] cyc_abs; // Error magnitude in cycles
  logic signed [PH_W-1:0] meas; // Combined measured phase
  logic signed [PH_W-1:0] lim; // Allowed loop phase magnitude
  logic [15:0] shift_tgt; // Phase shift target

  // Damping factor by code and bandwidth class
  function automatic logic [7:0] damp_factor(input logic [2:0] code, input logic [2:0] bw);
    logic [7:0] f;
    f = DF_5;
    unique case (code)
      DAMP_1: f = (bw >= BW_18HZ) ? DF_1P2 : (bw == BW_8HZ) ? DF_2P5 : DF_5;
      DAMP_2: f = (bw >= BW_18HZ) ? DF_2P5 : DF_5;
      DAMP_4: f = (bw >= BW_35HZ) ? DF_10 : DF_5;
      DAMP_5: f = (bw == BW_70HZ) ? DF_20 : (bw == BW_35HZ) ? DF_10 : DF_5;
      default: f = DF_5;
    endcase
    return f;
  endfunction

  // ----------------------------------------------------------------
  // Phase detector arithmetic
  // ----------------------------------------------------------------
  // Span, magnitude, measurement and clamp limit
  always_comb begin
    if (s_q.coarse[COARSE_MSB:0] > COARSE_TOP_CODE) begin
      span = SPAN_MAX;
    end else begin
      span = 13'((13'h0002 << s_q.coarse[COARSE_MSB:0]) - 13'h0001);
    end
    cyc_abs = meas_cycles[CYC_W-1] ? CYC_W'(-meas_cycles) : meas_cycles;
    meas = {meas_cycles, meas_frac};
    if (s_q.coarse[BIT_MULTI] && s_q.coarse[BIT_WIDE]) begin
      lim = PH_W'({span, {FRAC_W{1'b0}}});
    end else begin
      lim = PH_W'({SPAN_ONE, {FRAC_W{1'b0}}});
    end
  end

  assign shift_tgt = buildout_on ? 16'h0000 : {s_q.shift_hi, s_q.shift_lo};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Register writes, read data, damping, loss, loop phase and shift ramp
  always_comb begin
    s_d = s_q;
    s_d.rdata = RDATA_NONE;
    if (cpu_req.cs && cpu_req.wr) begin
      unique case (cpu_req.addr)
        OFS_MAIN_DAMP: s_d.damp = cpu_req.wdata;
        OFS_AUX_GAIN: s_d.aux_gain = cpu_req.wdata;
        OFS_MAIN_GAIN: s_d.main_gain = cpu_req.wdata;
        OFS_SHIFT_LO: s_d.shift_lo = cpu_req.wdata;
        OFS_SHIFT_HI: s_d.shift_hi = cpu_req.wdata;
        OFS_BUILDOUT: s_d.buildout = cpu_req.wdata & {2'b00, BUILDOUT_MASK};
        OFS_FINE: s_d.fine = cpu_req.wdata;
        OFS_COARSE: s_d.coarse = cpu_req.wdata;
        default: s_d.rdata = RDATA_NONE;
      endcase
    end
    if (cpu_req.cs && cpu_req.rd) begin
      unique case (cpu_req.addr)
        OFS_MAIN_DAMP: s_d.rdata = s_q.damp;
        OFS_AUX_GAIN: s_d.rdata = s_q.aux_gain;
        OFS_MAIN_GAIN: s_d.rdata = s_q.main_gain;
        OFS_SHIFT_LO: s_d.rdata = s_q.shift_lo;
        OFS_SHIFT_HI: s_d.rdata = s_q.shift_hi;
        OFS_BUILDOUT: s_d.rdata = s_q.buildout;
        OFS_FINE: s_d.rdata = s_q.fine;
        OFS_COARSE: s_d.rdata = s_q.coarse;
        default: s_d.rdata = RDATA_NONE;
      endcase
    end
    // Damping factor; unused codes fall back to 5
    s_d.damp_x10 = damp_factor(s_q.damp[LO_FIELD_MSB:0], main_bw_class);
    // Phase loss from the enabled detectors
    s_d.loss = (s_q.fine[BIT_ENABLE] && (fine_err > s_q.fine[LO_FIELD_MSB:0]))
      || (s_q.coarse[BIT_ENABLE] && (cyc_abs > CYC_W'(span)))
      || (s_q.fine[BIT_INACT] && ref_inactive);
    // Loop phase clamped to the allowed range
    if (meas > lim) begin
      s_d.loop_phase = lim;
    end else if (meas < -lim) begin
      s_d.loop_phase = -lim;
    end else begin
      s_d.loop_phase = meas;
    end
    // Output shift: jump when free or ramp_off is set, step by one while locked with the ramp enabled
    unique case (s_q.ramp)
      RAMP_HOLD: begin
        if (s_q.shift_out != shift_tgt) begin
          if (loop_locked && !ramp_off) begin
            s_d.ramp = RAMP_MOVE;
          end else begin
            s_d.shift_out = shift_tgt;
          end
        end
      end
      RAMP_MOVE: begin
        if (s_q.shift_out == shift_tgt) begin
          s_d.ramp = RAMP_HOLD;
        end else if ($signed(s_q.shift_out) < $signed(shift_tgt)) begin
          s_d.shift_out = 16'(s_q.shift_out + 16'h0001);
        end else begin
          s_d.shift_out = 16'(s_q.shift_out - 16'h0001);
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Register all state; reset loads documented defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.damp <= RST_MAIN_DAMP;
      s_q.aux_gain <= RST_GAIN;
      s_q.main_gain <= RST_GAIN;
      s_q.shift_lo <= RST_SHIFT_LO;
      s_q.shift_hi <= RST_SHIFT_HI;
      s_q.buildout <= RST_BUILDOUT;
      s_q.fine <= RST_FINE;
      s_q.coarse <= RST_COARSE;
      s_q.rdata <= RDATA_NONE;
      s_q.damp_x10 <= DF_5;
      s_q.loss <= 1'b0;
      s_q.loop_phase <= '0;
      s_q.shift_out <= 16'h0000;
      s_q.ramp <= RAMP_HOLD;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Gain selectors
  // ----------------------------------------------------------------
  // Main loop gain; low-rate field lives in the damping register
  pd_gain_select u_main_gain (
    .clk(clk),
    .rst(rst),
    .auto_on(s_q.main_gain[BIT_ENABLE]),
    .lowrate_gain(s_q.damp[HI_FIELD_MSB:HI_FIELD_LSB]),
    .highrate_gain(s_q.main_gain[HI_FIELD_MSB:HI_FIELD_LSB]),
    .digital_gain(s_q.main_gain[LO_FIELD_MSB:0]),
    .mode(main_mode),
    .gain_q(main_pd_gain)
  );

  // Auxiliary loop gain
  pd_gain_select u_aux_gain (
    .clk(clk),
    .rst(rst),
    .auto_on(s_q.aux_gain[BIT_ENABLE]),
    .lowrate_gain(aux_lowrate_analog_gain),
    .highrate_gain(s_q.aux_gain[HI_FIELD_MSB:HI_FIELD_LSB]),
    .digital_gain(s_q.aux_gain[LO_FIELD_MSB:0]),
    .mode(aux_mode),
    .gain_q(aux_pd_gain)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cpu_rdata = s_q.rdata;
  assign main_loop_damping_sel = s_q.damp[LO_FIELD_MSB:0];
  assign damping_x10 = s_q.damp_x10;
  assign phase_loss = s_q.loss;
  assign wide_range_on = s_q.coarse[BIT_WIDE];
  assign multicycle_response_on = s_q.coarse[BIT_MULTI];
  assign loop_phase = s_q.loop_phase;
  assign output_shift = s_q.shift_out;
  assign buildout_mean_shift = s_q.buildout[5:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_damp_unused: assert property ((main_loop_damping_sel == 3'h0 || main_loop_damping_sel > DAMP_5)
    |=> damping_x10 == DF_5) else $error("unused damping code not 5");
  a_damp_fast: assert property ((main_loop_damping_sel == DAMP_5 && main_bw_class == BW_70HZ)
    |=> damping_x10 == DF_20) else $error("damping 20 missing");
  a_damp_reset: assert property (@(posedge clk) disable iff (1'b0) $fell(rst)
    |-> main_loop_damping_sel == RST_MAIN_DAMP[2:0]) else $error("damping reset wrong");
  a_gain_lowrate: assert property ((!rst && s_q.main_gain[BIT_ENABLE] && main_mode.analog_fb && main_mode.low_rate)
    |=> main_pd_gain == $past(s_q.damp[HI_FIELD_MSB:HI_FIELD_LSB])) else $error("low-rate gain");
  a_gain_digital: assert property (!rst && (!s_q.main_gain[BIT_ENABLE] || !main_mode.analog_fb)
    |=> main_pd_gain == $past(s_q.main_gain[LO_FIELD_MSB:0])) else $error("digital gain");
  a_gain_highrate: assert property ((!rst && s_q.aux_gain[BIT_ENABLE] && aux_mode.analog_fb && !aux_mode.low_rate)
    |=> aux_pd_gain == $past(s_q.aux_gain[HI_FIELD_MSB:HI_FIELD_LSB])) else $error("high-rate gain");
  a_fine_loss: assert property ((!rst && s_q.fine[BIT_ENABLE] && fine_err > s_q.fine[LO_FIELD_MSB:0])
    |=> phase_loss) else $error("fine loss missed");
  a_no_loss: assert property ((!s_q.fine[BIT_ENABLE] && !s_q.coarse[BIT_ENABLE] && !ref_inactive)
    |=> !phase_loss) else $error("loss with detectors off");
  a_coarse_loss: assert property ((s_q.coarse[BIT_ENABLE] && s_q.coarse[COARSE_MSB:0] == 4'h0 && cyc_abs > 15'h0001)
    |=> phase_loss) else $error("coarse loss missed");
  a_phase_360: assert property (!s_q.coarse[BIT_MULTI] |=> (loop_phase <= 26'sh0000800)
    && (loop_phase >= -26'sh0000800)) else $error("loop phase beyond 360");
  a_wide_pass: assert property ((s_q.coarse[BIT_MULTI] && s_q.coarse[BIT_WIDE] && cyc_abs < CYC_W'(span))
    |=> loop_phase == $past(meas)) else $error("multi-cycle phase not passed");
  a_shift_bo: assert property ((buildout_on && (!loop_locked || ramp_off) && s_q.ramp == RAMP_HOLD)
    |=> output_shift == 16'h0000) else $error("shift not ignored in build-out");
  a_shift_step: assert property ((s_q.ramp == RAMP_MOVE && s_q.shift_out != shift_tgt)
    |=> (output_shift - $past(output_shift) == 16'h0001) || ($past(output_shift) - output_shift == 16'h0001))
    else $error("ramp step not one");

  c_ramp: cover property (s_q.ramp == RAMP_MOVE ##1 s_q.ramp == RAMP_HOLD);
  c_coarse_loss: cover property (s_q.coarse[BIT_ENABLE] && phase_loss);
  c_multi: cover property (multicycle_response_on && wide_range_on && loop_phase > 26'sh0000800);

endmodule

// ===== logic/pd_gain_select.sv
// Secondary phase detector gain choice for one loop
`timescale 1ns/10ps

module pd_gain_select
  import dpll_pd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic auto_on,
  input wire logic [2:0] lowrate_gain,
  input wire logic [2:0] highrate_gain,
  input wire logic [2:0] digital_gain,
  input wire loop_mode_t mode,
  output logic [2:0] gain_q
);

  // ----------------------------------------------------------------
  // Gain choice
  // ----------------------------------------------------------------
  logic [2:0] gain_d; // Next gain

  // Pick the gain field from the locking mode
  always_comb begin
    if (!auto_on) begin
      gain_d = digital_gain;
    end else if (!mode.analog_fb) begin
      gain_d = digital_gain;
    end else if (mode.low_rate) begin
      gain_d = lowrate_gain;
    end else begin
      gain_d = highrate_gain;
    end
  end

  // Register the choice; digital gain reset field
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gain_q <= RST_GAIN[2:0];
    end else begin
      gain_q <= gain_d;
    end
  end

endmodule

// ===== testbench/dpll_phase_detector_config_tb_top.sv
// Self-checking testbench for the loop phase-detector configuration block
`timescale 1ns/10ps

module dpll_phase_detector_config_tb_top import dpll_pd_pkg::*;;
  // ----------------------------------------------------------------
  // Signals, counters and the comparison macro
  // ----------------------------------------------------------------
  `define CHK(nm, ex, ac) begin compares++; if ((ac) !== (ex)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, ex, ac); end end
  logic clk;
  logic rst;
  cpu_req_t cpu_req;
  logic [7:0] cpu_rdata;
  loop_mode_t main_mode;
  loop_mode_t aux_mode;
  logic [2:0] aux_lowrate_analog_gain;
  logic [2:0] main_bw_class;
  logic signed [CYC_W-1:0] meas_cycles;
  logic [FRAC_W-1:0] meas_frac;
  logic [2:0] fine_err;
  logic ref_inactive, loop_locked, buildout_on, ramp_off;
  logic [2:0] main_loop_damping_sel;
  logic [7:0] damping_x10;
  logic [2:0] main_pd_gain;
  logic [2:0] aux_pd_gain;
  logic phase_loss, wide_range_on, multicycle_response_on;
  logic signed [PH_W-1:0] loop_phase;
  logic signed [15:0] output_shift;
  logic [5:0] buildout_mean_shift;
  int error_cnt = 0;
  int compares = 0;
  logic [7:0] d;
  logic signed [15:0] prev;
  int n;
  // Gain row: auto enable, feedback mode, expected main and aux gain
  typedef struct packed {logic au; logic af; logic lr; logic [2:0] em; logic [2:0] ea;} gain_row_t;
  // Phase row: fine cfg, coarse cfg, fine error, inactive, cycles, fraction, loss, loop phase
  typedef struct packed {
    logic [7:0] fc; logic [7:0] cc; logic [2:0] fe; logic ia;
    logic [14:0] cy; logic [10:0] fr; logic lo; logic [25:0] ph;
  } ph_row_t;
  logic [7:0] ofs_tab [8] = '{8'h6B, 8'h6C, 8'h6D, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74};
  logic [7:0] rst_tab [8] = '{8'h13, 8'hC2, 8'hC2, 8'h00, 8'h00, 8'h00, 8'hA2, 8'h85};
  gain_row_t gain_tab [7] = '{'{0, 0, 0, 3'h3, 3'h1}, '{0, 1, 1, 3'h3, 3'h1}, '{0, 1, 0, 3'h3, 3'h1},
    '{1, 0, 0, 3'h3, 3'h1}, '{1, 0, 1, 3'h3, 3'h1}, '{1, 1, 1, 3'h6, 3'h7}, '{1, 1, 0, 3'h5, 3'h4}};
  ph_row_t ph_tab [17] = '{
    '{8'hA2, 8'h85, 3'h2, 1'b0, 15'd0, 11'h100, 1'b0, 26'd256},
    '{8'hA2, 8'h85, 3'h3, 1'b0, 15'd0, 11'h000, 1'b1, 26'd0},
    '{8'h22, 8'h85, 3'h7, 1'b0, 15'd0, 11'h000, 1'b0, 26'd0},
    '{8'h22, 8'h85, 3'h0, 1'b0, 15'd63, 11'h000, 1'b0, 26'd2048},
    '{8'h22, 8'h85, 3'h0, 1'b0, 15'd64, 11'h000, 1'b1, 26'd2048},
    '{8'h22, 8'h85, 3'h0, 1'b0, -15'sd64, 11'h000, 1'b1, -26'sd2048},
    '{8'h22, 8'h05, 3'h0, 1'b0, 15'd100, 11'h000, 1'b0, 26'd2048},
    '{8'h22, 8'h8B, 3'h0, 1'b0, 15'd4096, 11'h000, 1'b1, 26'd2048},
    '{8'h22, 8'h8C, 3'h0, 1'b0, 15'd8191, 11'h000, 1'b0, 26'd2048},
    '{8'h62, 8'h05, 3'h0, 1'b1, 15'd0, 11'h000, 1'b1, 26'd0},
    '{8'h22, 8'h05, 3'h0, 1'b1, 15'd0, 11'h000, 1'b0, 26'd0},
    '{8'h22, 8'h65, 3'h0, 1'b0, 15'd5, 11'h010, 1'b0, 26'd10256},
    '{8'h22, 8'h65, 3'h0, 1'b0, 15'd100, 11'h000, 1'b0, 26'd129024},
    '{8'h22, 8'h45, 3'h0, 1'b0, 15'd5, 11'h000, 1'b0, 26'd2048},
    '{8'h22, 8'h6C, 3'h0, 1'b0, 15'd10000, 11'h000, 1'b0, 26'd16775168},
    '{8'h22, 8'h80, 3'h0, 1'b0, 15'd2, 11'h000, 1'b1, 26'd2048},
    '{8'h22, 8'h80, 3'h0, 1'b0, -15'sd1, 11'h7FF, 1'b0, -26'sd1}};

  // ----------------------------------------------------------------
  // Design under test
  // ----------------------------------------------------------------
  dpll_phase_detector_config dpll_phase_detector_config_i (
    .clk(clk), .rst(rst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .main_mode(main_mode), .aux_mode(aux_mode), .aux_lowrate_analog_gain(aux_lowrate_analog_gain),
    .main_bw_class(main_bw_class), .meas_cycles(meas_cycles), .meas_frac(meas_frac),
    .fine_err(fine_err), .ref_inactive(ref_inactive), .loop_locked(loop_locked),
    .buildout_on(buildout_on), .ramp_off(ramp_off), .main_loop_damping_sel(main_loop_damping_sel),
    .damping_x10(damping_x10), .main_pd_gain(main_pd_gain), .aux_pd_gain(aux_pd_gain),
    .phase_loss(phase_loss), .wide_range_on(wide_range_on), .multicycle_response_on(multicycle_response_on),
    .loop_phase(loop_phase), .output_shift(output_shift), .buildout_mean_shift(buildout_mean_shift)
  );

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and helpers
  // ----------------------------------------------------------------
  // Register write: request held for one taken edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    cpu_req <= {3'b110, a, v};
    @(posedge clk);
    cpu_req <= '0;
  endtask

  // Register read: data sampled in the cycle after the taken edge
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    cpu_req <= {3'b101, a, 8'h00};
    @(posedge clk);
    cpu_req <= '0;
    @(negedge clk);
    v = cpu_rdata;
  endtask

  // Let k edges pass and stop where outputs are settled
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  // Expected damping factor times ten by code and bandwidth class
  function automatic logic [7:0] df(input int c, input int b);
    case (c)
      1: return (b == 0) ? 8'h32 : (b == 1) ? 8'h19 : 8'h0C;
      2: return (b < 2) ? 8'h32 : 8'h19;
      4: return (b < 3) ? 8'h32 : 8'h64;
      5: return (b < 3) ? 8'h32 : (b == 3) ? 8'h64 : 8'hC8;
      default: return 8'h32;
    endcase
  endfunction

  // All reset values through the register port
  task automatic check_reset();
    for (int i = 0; i < 8; i++) begin
      reg_rd(ofs_tab[i], d);
      `CHK("reset value", rst_tab[i], d)
    end
    `CHK("damping sel", 3'h3, main_loop_damping_sel)
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cpu_req = '0;
    main_mode = '0;
    aux_mode = '0;
    aux_lowrate_analog_gain = 3'h7;
    main_bw_class = 3'h0;
    meas_cycles = '0;
    meas_frac = '0;
    fine_err = 3'h0;
    {ref_inactive, loop_locked, buildout_on, ramp_off} = 4'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    check_reset();
    `CHK("damping reset", 8'h32, damping_x10)
    // Gain choice rows, low-rate analog gain 6 held in the damping register
    reg_wr(OFS_MAIN_DAMP, 8'h63);
    foreach (gain_tab[i]) begin
      reg_wr(OFS_MAIN_GAIN, {gain_tab[i].au, 7'h53});
      reg_wr(OFS_AUX_GAIN, {gain_tab[i].au, 7'h41});
      main_mode <= {gain_tab[i].af, gain_tab[i].lr};
      aux_mode <= {gain_tab[i].af, gain_tab[i].lr};
      tick(1);
      `CHK("main gain", gain_tab[i].em, main_pd_gain)
      `CHK("aux gain", gain_tab[i].ea, aux_pd_gain)
    end
    // Every damping code, unused ones included, at every bandwidth class
    for (int c = 0; c < 8; c++) begin
      reg_wr(OFS_MAIN_DAMP, 8'(c));
      for (int b = 0; b < 5; b++) begin
        @(posedge clk);
        main_bw_class <= 3'(b);
        tick(1);
        `CHK("damping factor", df(c, b), damping_x10)
        `CHK("damping sel", 3'(c), main_loop_damping_sel)
      end
    end
    // Phase loss and loop phase rows
    foreach (ph_tab[i]) begin
      reg_wr(OFS_FINE, ph_tab[i].fc);
      reg_wr(OFS_COARSE, ph_tab[i].cc); // rows that set multi-cycle also set wide-range
      fine_err <= ph_tab[i].fe;
      ref_inactive <= ph_tab[i].ia;
      meas_cycles <= ph_tab[i].cy;
      meas_frac <= ph_tab[i].fr;
      tick(1);
      `CHK("phase loss", ph_tab[i].lo, phase_loss)
      `CHK("loop phase", ph_tab[i].ph, loop_phase)
      `CHK("wide range", ph_tab[i].cc[6], wide_range_on)
      `CHK("multi cycle", ph_tab[i].cc[5], multicycle_response_on)
    end
    // Unmapped read, one-cycle read data, write and read in the same cycle
    reg_rd(8'h75, d);
    `CHK("unmapped read", 8'h00, d)
    reg_rd(OFS_COARSE, d);
    @(negedge clk);
    `CHK("read data released", 8'h00, cpu_rdata)
    @(posedge clk);
    cpu_req <= {3'b111, OFS_BUILDOUT, 8'hFF};
    @(posedge clk);
    cpu_req <= '0;
    @(negedge clk);
    `CHK("read before write", 8'h00, cpu_rdata)
    reg_rd(OFS_BUILDOUT, d);
    `CHK("buildout reg", 8'h3F, d)
    `CHK("buildout port", 6'h3F, buildout_mean_shift)
    // Phase shift: jumps while unlocked, signed high byte
    reg_wr(OFS_SHIFT_LO, 8'h05);
    reg_wr(OFS_SHIFT_HI, 8'h80);
    tick(2);
    `CHK("shift signed", 16'h8005, output_shift)
    reg_wr(OFS_SHIFT_HI, 8'h00);
    tick(2);
    `CHK("shift jump", 16'h0005, output_shift)
    // Locked: the shift ramps one step per cycle
    @(posedge clk);
    loop_locked <= 1'b1;
    reg_wr(OFS_SHIFT_LO, 8'h09);
    prev = 16'sh0005;
    n = 0;
    while (output_shift !== 16'sh0009 && n < 20) begin
      @(negedge clk);
      `CHK("ramp step", 1'b1, (output_shift - prev) inside {16'sh0000, 16'sh0001})
      prev = output_shift;
      n++;
    end
    `CHK("ramp length", 1'b1, n >= 4 && n <= 8)
    // Ramp disabled, then build-out forcing the shift to zero
    @(posedge clk);
    ramp_off <= 1'b1;
    reg_wr(OFS_SHIFT_LO, 8'h01);
    tick(2);
    `CHK("ramp off jump", 16'h0001, output_shift)
    @(posedge clk);
    buildout_on <= 1'b1;
    tick(3);
    `CHK("buildout shift", 16'h0000, output_shift)
    // Second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check_reset();
    end_sim();
  end
endmodule
